// ==== nv_memory_read_write_ctrl_tb.sv ====
`timescale 1ns/1ps
module nv_memory_read_write_ctrl_tb
  import nvc_pkg::*;
();
  logic        mclk, srst, psel, penable, pwrite, pready, pslverr;
  logic        writeBusy, writeDoneFlag;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [12:0] pfAddr;
  logic [13:0] pfWord;
  int          bad_count, num_checks;
  nvc_link_if  link ();

  // Flash stand-in: a scramble of the address, so neighbouring words differ.
  function automatic logic [13:0] pf_model(input logic [12:0] a);
    return {a[5:0], a[12:5]} ^ 14'h2d1b;
  endfunction : pf_model
  assign pfWord = pf_model(pfAddr);

  nvc_device nvc_device_i (.mclk(mclk), .srst(srst), .link(link.device), .pfAddr(pfAddr),
    .pfWord(pfWord), .writeBusy(writeBusy), .writeDoneFlag(writeDoneFlag));
  nvc_host nvc_host_i (.mclk(mclk), .srst(srst), .link(link.host), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  nvc_link_monitor nvc_link_monitor_i (.mclk(mclk), .srst(srst), .acc(link.acc), .wr(link.wr),
    .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ignored(link.ignored),
    .writeBusy(writeBusy), .writeDoneFlag(writeDoneFlag));

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One APB transfer; the request stands until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr32

  // Issues one command and polls status until busy drops, under a bound.
  task automatic run_cmd(input logic [12:0] a, input logic [7:0] d, input logic [1:0] c,
                         output logic [31:0] st);
    logic e;
    int   n;
    wr32(APB_ADDR, {19'h0, a});
    wr32(APB_DATA, {24'h0, d});
    wr32(APB_GO, {30'h0, c});
    n = 0;
    do begin
      apb(1'b0, APB_STATUS, 32'h0, st, e);
      n++;
    end while (st[STAT_BUSY_BIT] !== 1'b0 && n < 1000);
    if (st[STAT_BUSY_BIT] !== 1'b0) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : run_cmd

  task automatic t_reset_state();
    logic [31:0] q;
    logic        e;
    apb(1'b0, APB_STATUS, 32'h0, q, e);
    check("status after reset", 32'h0, q);
    apb(1'b0, 8'h10, 32'h0, q, e);
    check("unmapped error", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, q);
  endtask : t_reset_state

  // Two writes to distinct bytes, then both read back, so the address matters.
  task automatic t_ee_write_read();
    logic [12:0] ad [2] = '{13'h005, 13'h0ff};
    logic [7:0]  dt [2] = '{8'ha7, 8'h3c};
    logic [31:0] st;
    logic        e;
    for (int i = 0; i < 2; i++) begin
      run_cmd(ad[i], dt[i], CMD_EE_WRITE, st);
      check("done seen", 32'h1, {31'h0, st[STAT_DONE_BIT]});
      check("done flag port", 32'h0, {31'h0, writeDoneFlag});
      wr32(APB_STATUS, 32'h2);
      apb(1'b0, APB_STATUS, 32'h0, st, e);
      check("done cleared", 32'h0, {31'h0, st[STAT_DONE_BIT]});
    end
    for (int i = 0; i < 2; i++) begin
      run_cmd(ad[i], 8'h00, CMD_EE_READ, st);
      check("eeprom byte", {24'h0, dt[i]}, {24'h0, st[STAT_RES_LSB+7 -: 8]});
    end
  endtask : t_ee_write_read

  // Flash words at the top and near the bottom of the address range use all 13 bits.
  task automatic t_flash_read();
    logic [12:0] ad [3] = '{13'h1fff, 13'h0001, 13'h1abc};
    logic [31:0] st;
    for (int i = 0; i < 3; i++) begin
      run_cmd(ad[i], 8'h00, CMD_PF_READ, st);
      check("flash word", {18'h0, pf_model(ad[i])}, {18'h0, st[STAT_RES_LSB+13 -: 14]});
    end
  endtask : t_flash_read

  // Reset is held for eight cycles before the scenarios run.
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} <= {1'b1, 43'h0};
    bad_count = 0;
    num_checks = 0;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    t_reset_state();
    t_ee_write_read();
    t_flash_read();
    tally_and_finish();
  end
endmodule : nv_memory_read_write_ctrl_tb

// ==== nvc_device.sv ====
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module nvc_device
  import nvc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  nvc_link_if.device       link,
  output      logic [12:0] pfAddr,
  input  wire logic [13:0] pfWord,
  output      logic        writeBusy,
  output      logic        writeDoneFlag
);

  // ---------------------------------------------------------------------------
  // Storage.
  // ---------------------------------------------------------------------------
  logic [7:0]             eeMem [0:255];
  logic [7:0]             addrLow;
  logic [ADDR_HIGH_W-1:0] addrHigh;
  logic [7:0]             dataLow;
  logic [DATA_HIGH_W-1:0] dataHigh;
  logic                   selProg;
  logic                   permit;
  logic                   wrBit;
  logic                   rdBit;
  logic                   doneFlag;
  logic [15:0]            wrCnt;
  logic [7:0]             wrAddr;
  logic [7:0]             wrData;
  logic [1:0]             skipCnt;
  nvc_key_type            keyState;

  logic [7:0]             next_addrLow;
  logic [ADDR_HIGH_W-1:0] next_addrHigh;
  logic [7:0]             next_dataLow;
  logic [DATA_HIGH_W-1:0] next_dataHigh;
  logic                   next_selProg;
  logic                   next_permit;
  logic                   next_wrBit;
  logic                   next_rdBit;
  logic                   next_doneFlag;
  logic [15:0]            next_wrCnt;
  logic [7:0]             next_wrAddr;
  logic [7:0]             next_wrData;
  logic [1:0]             next_skipCnt;
  nvc_key_type            next_keyState;

  logic                   take;
  logic                   wrHit;
  logic                   memWrite;
  logic                   startWrite;

  // ---------------------------------------------------------------------------
  // Access qualification.
  // ---------------------------------------------------------------------------
  // The second cycle after a flash trigger belongs to the flash fetch, so
  // whatever the core presents then is dropped.
  assign link.ignored = (skipCnt == SKIP_IGNORE);
  assign take         = link.acc && !link.ignored;
  assign wrHit        = take && link.wr;
  assign pfAddr       = {addrHigh, addrLow};
  assign writeBusy    = wrBit;
  assign writeDoneFlag = doneFlag;
  assign memWrite     = wrBit && (wrCnt == 16'h0001);

  // A start needs the full key sequence, a permit already set before this
  // write, data space selected, and no write already running.
  assign startWrite = wrHit && (link.addr == REG_CONTROL) && link.wdata[CTRL_WR_BIT]
                      && (keyState == KEY_GOT2)
                      && permit
                      && !link.wdata[CTRL_SEL_BIT]
                      && !wrBit;

  // Read-back mux; unused upper bits read as zero.
  always_comb begin
    case (link.addr)
      REG_ADDR_LOW:  link.rdata = addrLow;
      REG_ADDR_HIGH: link.rdata = {{(8 - ADDR_HIGH_W){1'b0}}, addrHigh};
      REG_DATA_LOW:  link.rdata = dataLow;
      REG_DATA_HIGH: link.rdata = {{(8 - DATA_HIGH_W){1'b0}}, dataHigh};
      REG_CONTROL:   link.rdata = {selProg, 4'h0, permit, wrBit, rdBit};
      REG_FLAG:      link.rdata = {7'h00, doneFlag};
      default:       link.rdata = RST_BYTE;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Unlock key tracking.
  // ---------------------------------------------------------------------------
  // Any access not dropped as a flash-fetch cycle between the keys and the trigger breaks the sequence,
  // which is what makes a runaway program unlikely to write by accident.
  always_comb begin
    next_keyState = keyState;
    case (keyState)
      KEY_IDLE: begin
        if (wrHit && link.addr == REG_UNLOCK && link.wdata == KEY_FIRST) begin
          next_keyState = KEY_GOT1;
        end
      end
      KEY_GOT1: begin
        if (take) begin
          if (wrHit && link.addr == REG_UNLOCK && link.wdata == KEY_SECOND) begin
            next_keyState = KEY_GOT2;
          end else begin
            next_keyState = KEY_IDLE;
          end
        end
      end
      KEY_GOT2: begin
        if (take) begin
          next_keyState = KEY_IDLE;
        end
      end
      default: next_keyState = KEY_IDLE;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Register and write-cycle next values.
  // ---------------------------------------------------------------------------
  always_comb begin
    next_addrLow  = addrLow;
    next_addrHigh = addrHigh;
    next_dataLow  = dataLow;
    next_dataHigh = dataHigh;
    next_selProg  = selProg;
    next_permit   = permit;
    next_wrBit    = wrBit;
    next_rdBit    = 1'b0;
    next_doneFlag = doneFlag;
    next_wrCnt    = wrCnt;
    next_wrAddr   = wrAddr;
    next_wrData   = wrData;
    next_skipCnt  = (skipCnt != 2'h0) ? skipCnt - 2'h1 : skipCnt;
    if (wrHit) begin
      case (link.addr)
        REG_ADDR_LOW:  next_addrLow  = link.wdata;
        REG_ADDR_HIGH: next_addrHigh = link.wdata[ADDR_HIGH_W-1:0];
        REG_DATA_LOW:  next_dataLow  = link.wdata;
        REG_DATA_HIGH: next_dataHigh = link.wdata[DATA_HIGH_W-1:0];
        REG_FLAG:      next_doneFlag = link.wdata[FLAG_DONE_BIT];
        REG_CONTROL: begin
          next_selProg = link.wdata[CTRL_SEL_BIT];
          next_permit  = link.wdata[CTRL_PERMIT_BIT];
          if (link.wdata[CTRL_RD_BIT]) begin
            // The read completes at this edge, so the very next access sees it.
            next_rdBit = 1'b1;
            if (link.wdata[CTRL_SEL_BIT]) begin
              next_dataLow  = pfWord[7:0];
              next_dataHigh = pfWord[13:8];
              next_skipCnt  = SKIP_START;
            end else begin
              next_dataLow = eeMem[addrLow];
            end
          end
        end
        default: ;
      endcase
    end
    if (startWrite) begin
      next_wrBit  = 1'b1;
      next_wrCnt  = EE_WRITE_CYCLES;
      next_wrAddr = addrLow;
      next_wrData = dataLow;
    end else if (wrBit) begin
      // The running cycle ignores the permit bit once it has begun.
      next_wrCnt = wrCnt - 16'h0001;
      if (memWrite) begin
        next_wrBit    = 1'b0;
        next_doneFlag = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State registers.
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      addrLow  <= RST_BYTE;
      addrHigh <= '0;
      dataLow  <= RST_BYTE;
      dataHigh <= '0;
      selProg  <= 1'b0;
      permit   <= 1'b0;
      wrBit    <= 1'b0;
      rdBit    <= 1'b0;
      doneFlag <= 1'b0;
      wrCnt    <= '0;
      wrAddr   <= RST_BYTE;
      wrData   <= RST_BYTE;
      skipCnt  <= '0;
      keyState <= KEY_IDLE;
    end else begin
      addrLow  <= next_addrLow;
      addrHigh <= next_addrHigh;
      dataLow  <= next_dataLow;
      dataHigh <= next_dataHigh;
      selProg  <= next_selProg;
      permit   <= next_permit;
      wrBit    <= next_wrBit;
      rdBit    <= next_rdBit;
      doneFlag <= next_doneFlag;
      wrCnt    <= next_wrCnt;
      wrAddr   <= next_wrAddr;
      wrData   <= next_wrData;
      skipCnt  <= next_skipCnt;
      keyState <= next_keyState;
    end
  end

  // The array is committed at the end of the write cycle, from the address
  // and data captured at the start, so later register writes cannot alter it.
  always_ff @(posedge mclk) begin
    if (memWrite) begin
      eeMem[wrAddr] <= wrData;
    end
  end

endmodule : nvc_device

// ==== nvc_host.sv ====
`timescale 1ns/1ps
module nvc_host
  import nvc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  nvc_link_if.host         link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr
);

  logic [12:0]    cmdAddr;
  logic [7:0]     cmdData;
  logic [1:0]     cmd;
  logic [3:0]     idx;
  logic [13:0]    result;
  logic           doneSeen;
  nvc_hstate_type state;
  nvc_step_type   step;
  logic [31:0]    rdVal;
  logic           rdErr;

  logic [12:0]    next_cmdAddr;
  logic [7:0]     next_cmdData;
  logic [1:0]     next_cmd;
  logic [3:0]     next_idx;
  logic [13:0]    next_result;
  logic           next_doneSeen;
  nvc_hstate_type next_state;
  nvc_step_type   next_step;
  logic           apbWrite;

  // ---------------------------------------------------------------------------
  // Access sequences, one step per cycle except while a poll step waits on the write bit.
  // ---------------------------------------------------------------------------
  // Each write, read or poll step is one register access; the running list never pauses between
  // the keys and the trigger, so no other access can break the sequence.
  function automatic nvc_step_type stepOf(input logic [1:0]  c,
                                          input logic [3:0]  i,
                                          input logic [12:0] a,
                                          input logic [7:0]  d);
    nvc_step_type s;
    s = '{op: OP_END, regSel: REG_ADDR_LOW, data: RST_BYTE};
    case ({c, i})
      {CMD_EE_READ, 4'h0}:  s = '{OP_WR, REG_ADDR_LOW, a[7:0]};
      {CMD_EE_READ, 4'h1}:  s = '{OP_WR, REG_CONTROL, CTRL_EE_READ};
      {CMD_EE_READ, 4'h2}:  s = '{OP_RD, REG_DATA_LOW, RST_BYTE};
      {CMD_EE_WRITE, 4'h0}: s = '{OP_WR, REG_ADDR_LOW, a[7:0]};
      {CMD_EE_WRITE, 4'h1}: s = '{OP_WR, REG_DATA_LOW, d};
      {CMD_EE_WRITE, 4'h2}: s = '{OP_WR, REG_CONTROL, CTRL_PERMIT};
      {CMD_EE_WRITE, 4'h3}: s = '{OP_WR, REG_UNLOCK, KEY_FIRST};
      {CMD_EE_WRITE, 4'h4}: s = '{OP_WR, REG_UNLOCK, KEY_SECOND};
      {CMD_EE_WRITE, 4'h5}: s = '{OP_WR, REG_CONTROL, CTRL_PERMIT_WR};
      // Permit is dropped while the write still runs; the cycle must carry on regardless.
      {CMD_EE_WRITE, 4'h6}: s = '{OP_WR, REG_CONTROL, CTRL_CLEAR};
      {CMD_EE_WRITE, 4'h7}: s = '{OP_POLL, REG_CONTROL, RST_BYTE};
      {CMD_EE_WRITE, 4'h8}: s = '{OP_RD, REG_FLAG, RST_BYTE};
      {CMD_EE_WRITE, 4'h9}: s = '{OP_WR, REG_FLAG, CTRL_CLEAR};
      {CMD_PF_READ, 4'h0}:  s = '{OP_WR, REG_ADDR_LOW, a[7:0]};
      {CMD_PF_READ, 4'h1}:  s = '{OP_WR, REG_ADDR_HIGH, {3'h0, a[12:8]}};
      {CMD_PF_READ, 4'h2}:  s = '{OP_WR, REG_CONTROL, CTRL_PF_READ};
      {CMD_PF_READ, 4'h3}:  s = '{OP_IDLE, REG_ADDR_LOW, RST_BYTE};
      {CMD_PF_READ, 4'h4}:  s = '{OP_IDLE, REG_ADDR_LOW, RST_BYTE};
      {CMD_PF_READ, 4'h5}:  s = '{OP_RD, REG_DATA_LOW, RST_BYTE};
      {CMD_PF_READ, 4'h6}:  s = '{OP_RD, REG_DATA_HIGH, RST_BYTE};
      {CMD_PF_READ, 4'h7}:  s = '{OP_RD, REG_ADDR_HIGH, RST_BYTE};
      default: ;
    endcase
    return s;
  endfunction : stepOf

  // Link outputs come straight from the registered step.
  assign link.acc   = (state == HST_RUN) && (step.op inside {OP_WR, OP_RD, OP_POLL});
  assign link.wr    = (step.op == OP_WR);
  assign link.addr  = step.regSel;
  assign link.wdata = step.data;
  assign pready     = 1'b1;
  assign apbWrite   = psel && penable && pwrite;

  // ---------------------------------------------------------------------------
  // APB read data, taken in the setup cycle so it is stable in the access one.
  // ---------------------------------------------------------------------------
  always_comb begin
    rdErr = 1'b0;
    case (paddr)
      APB_ADDR:   rdVal = {19'h0, cmdAddr};
      APB_DATA:   rdVal = {24'h0, cmdData};
      APB_GO:     rdVal = {30'h0, cmd};
      APB_STATUS: rdVal = {2'h0, result, 14'h0, doneSeen, state == HST_RUN};
      default: begin
        rdVal = 32'h0;
        rdErr = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Command sequencer next values.
  // ---------------------------------------------------------------------------
  always_comb begin
    next_cmdAddr  = cmdAddr;
    next_cmdData  = cmdData;
    next_cmd      = cmd;
    next_idx      = idx;
    next_result   = result;
    next_doneSeen = doneSeen;
    next_state    = state;
    if (apbWrite) begin
      case (paddr)
        APB_ADDR: next_cmdAddr = pwdata[12:0];
        APB_DATA: next_cmdData = pwdata[7:0];
        APB_GO: begin
          if (state == HST_IDLE && pwdata[1:0] != CMD_NONE) begin
            next_cmd   = pwdata[1:0];
            next_idx   = 4'h0;
            next_state = HST_RUN;
          end
        end
        APB_STATUS: begin
          if (pwdata[STAT_DONE_BIT]) begin
            next_doneSeen = 1'b0;
          end
        end
        default: ;
      endcase
    end
    case (state)
      HST_RUN: begin
        if (step.op == OP_END) begin
          next_state = HST_IDLE;
        end else if (!(step.op == OP_POLL && link.rdata[CTRL_WR_BIT])) begin
          next_idx = idx + 4'h1;
        end
        if (step.op == OP_RD && step.regSel == REG_DATA_LOW) begin
          next_result[7:0] = link.rdata;
        end
        if (step.op == OP_RD && step.regSel == REG_DATA_HIGH) begin
          next_result[13:8] = link.rdata[5:0];
        end
        // Set wins over a software clear in the same cycle.
        if (step.op == OP_RD && step.regSel == REG_FLAG && link.rdata[FLAG_DONE_BIT]) begin
          next_doneSeen = 1'b1;
        end
      end
      HST_IDLE: ;
      default: next_state = HST_IDLE;
    endcase
    next_step = (next_state == HST_RUN) ?
                stepOf(next_cmd, next_idx, next_cmdAddr, next_cmdData) :
                '{op: OP_IDLE, regSel: REG_ADDR_LOW, data: RST_BYTE};
  end

  // ---------------------------------------------------------------------------
  // State registers.
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmdAddr  <= '0;
      cmdData  <= RST_BYTE;
      cmd      <= CMD_NONE;
      idx      <= '0;
      result   <= '0;
      doneSeen <= 1'b0;
      state    <= HST_IDLE;
      step     <= '{op: OP_IDLE, regSel: REG_ADDR_LOW, data: RST_BYTE};
      prdata   <= 32'h0;
      pslverr  <= 1'b0;
    end else begin
      cmdAddr  <= next_cmdAddr;
      cmdData  <= next_cmdData;
      cmd      <= next_cmd;
      idx      <= next_idx;
      result   <= next_result;
      doneSeen <= next_doneSeen;
      state    <= next_state;
      step     <= next_step;
      if (psel && !penable) begin
        prdata  <= rdVal;
        pslverr <= rdErr;
      end
    end
  end

endmodule : nvc_host

// ==== nvc_link_if.sv ====
`timescale 1ns/1ps
// Register access path from the core side to the controller. One access per
// cycle while acc is high; read data answers in the same cycle.
interface nvc_link_if;
  logic       acc;
  logic       wr;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ignored;

  modport device (
    input  acc,
    input  wr,
    input  addr,
    input  wdata,
    output rdata,
    output ignored
  );

  modport host (
    output acc,
    output wr,
    output addr,
    output wdata,
    input  rdata,
    input  ignored
  );
endinterface : nvc_link_if

// ==== nvc_link_monitor.sv ====
`timescale 1ns/1ps
module nvc_link_monitor
  import nvc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       acc,
  input wire logic       wr,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ignored,
  input wire logic       writeBusy,
  input wire logic       writeDoneFlag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // ---------------------------------------------------------------------------
  // Decoded accesses; a dropped cycle counts as no access at all.
  // ---------------------------------------------------------------------------
  wire         take      = acc && !ignored;
  wire         wrCtl     = take && wr && addr == REG_CONTROL;
  wire         flashTrig = wrCtl && wdata[CTRL_SEL_BIT] && wdata[CTRL_RD_BIT];
  wire         rdTrig    = wrCtl && wdata[CTRL_RD_BIT];
  wire         key1      = take && wr && addr == REG_UNLOCK && wdata == KEY_FIRST;
  wire         key2      = take && wr && addr == REG_UNLOCK && wdata == KEY_SECOND;
  wire         clrFlag   = take && wr && addr == REG_FLAG && !wdata[FLAG_DONE_BIT];
  logic [15:0] busyCnt;
  logic [15:0] next_busyCnt;
  logic        permitHeld;
  logic        next_permitHeld;

  // Last permit value the host wrote; a start must find it already set.
  always_comb next_permitHeld = wrCtl ? wdata[CTRL_PERMIT_BIT] : permitHeld;
  always_ff @(posedge mclk) permitHeld <= srst ? 1'b0 : next_permitHeld;

  // Counts the cycles of a running write, so its length is checked exactly.
  always_comb next_busyCnt = writeBusy ? busyCnt + 16'h0001 : 16'h0000;
  always_ff @(posedge mclk) busyCnt <= srst ? 16'h0000 : next_busyCnt;

  sequence s_unlock;
    key1 ##1 key2 ##1 (wrCtl && wdata[CTRL_WR_BIT] && !wdata[CTRL_SEL_BIT]);
  endsequence
  sequence s_skip;
    !ignored ##1 ignored;
  endsequence

  a_flash_skip: assert property (flashTrig |=> s_skip)
    else $error("Flash trigger not followed by one normal and one dropped cycle.");
  a_skip_cause: assert property (ignored |-> $past(flashTrig, 2))
    else $error("Dropped cycle without a flash trigger two cycles before.");
  a_keys_start: assert property (s_unlock |=> $rose(writeBusy))
    else $error("Full unlock sequence did not start a write.");
  a_start_cause: assert property ($rose(writeBusy) |-> $past(key2, 2) && $past(key1, 3))
    else $error("Write started without the two keys just before.");
  a_start_permit: assert property ($rose(writeBusy) |-> $past(permitHeld))
    else $error("Write started without the permit set beforehand.");
  a_write_length: assert property ($fell(writeBusy) |-> busyCnt == EE_WRITE_CYCLES)
    else $error("Write cycle length differs from the set count.");
  a_done_cause: assert property ($rose(writeDoneFlag) |-> $fell(writeBusy))
    else $error("Done flag rose apart from the end of a write.");
  a_done_holds: assert property (writeDoneFlag && !clrFlag |=> writeDoneFlag)
    else $error("Done flag fell without a host clear.");
  a_addr_hi_zero: assert property (take && !wr && addr == REG_ADDR_HIGH |-> rdata[7:5] == 3'h0)
    else $error("Unused high address bits read nonzero.");
  a_data_hi_zero: assert property (take && !wr && addr == REG_DATA_HIGH |-> rdata[7:6] == 2'h0)
    else $error("Unused high data bits read nonzero.");
  a_rd_self_clear: assert property (take && !wr && addr == REG_CONTROL && !$past(rdTrig)
                                    |-> !rdata[CTRL_RD_BIT])
    else $error("Read trigger bit still set after the read.");
endmodule : nvc_link_monitor

// ==== nvc_pkg.sv ====
// What this block does
// - EEPROM read: address, select data, trigger read.
// - EEPROM byte appears in low data next cycle.
// - Low data holds until next read or write.
// - Load address and data before a write.
// - Write starts only after keys 55h, AAh, trigger.
// - Keep key sequence and trigger uninterrupted.
// - Write trigger refused without write permit.
// - Write permit never cleared by hardware.
// - Host keeps write permit cleared when idle.
// - Clearing permit does not abort running write.
// - Write end clears trigger, sets done flag.
// - Done flag stays until host clears it.
// - Flash read: both addresses, select program, trigger.
// - Second access after flash trigger is ignored.
// - Flash word in both data registers, held.
// - Host idles two cycles after flash trigger.
// - Write trigger with program select is dropped.
// - High address uses bits 4-0, rest zero.
// - High data uses bits 5-0, rest zero.
package nvc_pkg;

  // ---------------------------------------------------------------------------
  // Register indexes on the link between core and controller.
  // ---------------------------------------------------------------------------
  localparam logic [2:0] REG_ADDR_LOW  = 3'h0;
  localparam logic [2:0] REG_ADDR_HIGH = 3'h1;
  localparam logic [2:0] REG_DATA_LOW  = 3'h2;
  localparam logic [2:0] REG_DATA_HIGH = 3'h3;
  localparam logic [2:0] REG_CONTROL   = 3'h4;
  localparam logic [2:0] REG_UNLOCK    = 3'h5;
  localparam logic [2:0] REG_FLAG      = 3'h6;

  // Field positions of the control register and the flag register, and widths of the high address and data registers.
  localparam int CTRL_SEL_BIT    = 7;
  localparam int CTRL_PERMIT_BIT = 2;
  localparam int CTRL_WR_BIT     = 1;
  localparam int CTRL_RD_BIT     = 0;
  localparam int FLAG_DONE_BIT   = 0;
  localparam int ADDR_HIGH_W     = 5;
  localparam int DATA_HIGH_W     = 6;

  // Unlock keys and control values the host writes.
  localparam logic [7:0] KEY_FIRST     = 8'h55;
  localparam logic [7:0] KEY_SECOND    = 8'haa;
  localparam logic [7:0] CTRL_EE_READ  = 8'h01;
  localparam logic [7:0] CTRL_PF_READ  = 8'h81;
  localparam logic [7:0] CTRL_PERMIT   = 8'h04;
  localparam logic [7:0] CTRL_PERMIT_WR = 8'h06;
  localparam logic [7:0] CTRL_CLEAR    = 8'h00;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ---------------------------------------------------------------------------
  // Timing.
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  localparam int EE_WRITE_TIME_NS  = 4000;
  localparam logic [15:0] EE_WRITE_CYCLES = 16'(EE_WRITE_TIME_NS / CLK_PERIOD_NS);
  localparam logic [1:0]  SKIP_START  = 2'h2;   // Counter value after a flash trigger.
  localparam logic [1:0]  SKIP_IGNORE = 2'h1;   // Counter value of the dropped cycle.

  // ---------------------------------------------------------------------------
  // Host command port on APB.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] APB_ADDR   = 8'h00;
  localparam logic [7:0] APB_DATA   = 8'h04;
  localparam logic [7:0] APB_GO     = 8'h08;
  localparam logic [7:0] APB_STATUS = 8'h0c;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_RES_LSB  = 16;
  localparam logic [1:0] CMD_NONE    = 2'h0;
  localparam logic [1:0] CMD_EE_READ = 2'h1;
  localparam logic [1:0] CMD_EE_WRITE = 2'h2;
  localparam logic [1:0] CMD_PF_READ = 2'h3;

  // ---------------------------------------------------------------------------
  // Types.
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_GOT1 = 3'b010,
    KEY_GOT2 = 3'b100
  } nvc_key_type;

  typedef enum logic [1:0] {
    HST_IDLE = 2'b01,
    HST_RUN  = 2'b10
  } nvc_hstate_type;

  typedef enum logic [4:0] {
    OP_IDLE = 5'b00001,
    OP_WR   = 5'b00010,
    OP_RD   = 5'b00100,
    OP_POLL = 5'b01000,
    OP_END  = 5'b10000
  } nvc_op_type;

  typedef struct packed {
    nvc_op_type op;
    logic [2:0] regSel;
    logic [7:0] data;
  } nvc_step_type;

endpackage : nvc_pkg
